// File: design/pis_pkg.sv
// Shared constants of the peripheral interrupt status block.
package pis_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;

  // Byte addresses of the registers, one aligned word each.
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_REASON = 8'h08;

  // Bit positions of the bus-state and DMA sources in the status word.
  localparam int unsigned BIT_BUS_RESET = 0;
  localparam int unsigned BIT_RESUME    = 1;
  localparam int unsigned BIT_SUSPEND   = 2;
  localparam int unsigned BIT_PSOF      = 3;
  localparam int unsigned BIT_SOF       = 4;
  localparam int unsigned BIT_DMA       = 5;

  // Endpoint n transmit sits at EP_BASE + 2n, receive at EP_BASE + 2n + 1.
  localparam int unsigned EP_BASE  = 8;
  localparam int unsigned EP_MAX   = 12;
  localparam int unsigned EP_COUNT = 8;

  // Width of the DMA cause register.
  localparam int unsigned DMA_REASON_W = 16;

  // Reset values.
  localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RST   = 32'hffff_ffff;

  // Register selector produced by the address decoder.
  typedef enum logic [1:0] {
    PIS_SEL_STATUS,
    PIS_SEL_MASK,
    PIS_SEL_REASON,
    PIS_SEL_NONE
  } pis_sel_t;

  // Response codes of the register bus.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pis_pkg

// File: design/pis_irq_status.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module pis_irq_status #(
  parameter int unsigned NUM_EP = pis_pkg::EP_COUNT
) (
  input  wire logic                              CLK,
  input  wire logic                              RESET,
  input  wire logic                              AWVALID,
  output logic                                   AWREADY,
  input  wire logic [pis_pkg::ADDR_W-1:0]        AWADDR,
  input  wire logic                              WVALID,
  output logic                                   WREADY,
  input  wire logic [pis_pkg::DATA_W-1:0]        WDATA,
  input  wire logic [pis_pkg::STRB_W-1:0]        WSTRB,
  output logic                                   BVALID,
  input  wire logic                              BREADY,
  output logic [1:0]                             BRESP,
  input  wire logic                              ARVALID,
  output logic                                   ARREADY,
  input  wire logic [pis_pkg::ADDR_W-1:0]        ARADDR,
  output logic                                   RVALID,
  input  wire logic                              RREADY,
  output logic [pis_pkg::DATA_W-1:0]             RDATA,
  output logic [1:0]                             RRESP,
  input  wire logic [NUM_EP-1:0]                 EP_TX_EVT,
  input  wire logic [NUM_EP-1:0]                 EP_RX_EVT,
  input  wire logic                              BUS_RESET_EVT,
  input  wire logic                              RESUME_EVT,
  input  wire logic                              SUSPEND_EVT,
  input  wire logic                              PSOF_EVT,
  input  wire logic                              SOF_EVT,
  input  wire logic [pis_pkg::DMA_REASON_W-1:0]  DMA_REASON_EVT,
  output logic                                   INT
);

  localparam int unsigned AW = pis_pkg::ADDR_W;
  localparam int unsigned DW = pis_pkg::DATA_W;
  localparam int unsigned SW = pis_pkg::STRB_W;
  localparam int unsigned RW = pis_pkg::DMA_REASON_W;

  // The block keeps three registers, each one aligned 32-bit word.
  // The status word is sticky: an event sets its bit and only a written one clears it.
  // The mask word has the same layout and decides which set bits reach INT.
  // The DMA cause word holds the individual DMA causes behind the summary bit.
  // Reserved positions of status and mask read as zero and ignore writes.
  // Endpoint positions above NUM_EP are reserved as well.
  // The cause word uses only its low RW bits; the upper bits read as zero.

  // Bus timing as the master sees it.
  // A write needs both halves, which may arrive in either order.
  // The response rises two cycles after the later half has been taken.
  // Both write ready lines stay low from their take until the response is accepted.
  // This allows one write at a time, which keeps the two-step DMA clear in order.
  // A read answers in the cycle after its address, with the value held before.
  // The read ready line stays low until the read data has been accepted.
  // Reads have no side effects, so polling the status word is always safe.
  // Unmapped addresses give an error response, no register change and zero data.
  // The error response is the only way software learns of a bad address.

  // Event inputs are pulses from logic on this clock, so they need no synchronisers.
  // A held event level sets its bit again every cycle, so a clear cannot win meanwhile.
  // INT is registered, so it follows a setting event or a clear by exactly one cycle.
  // Several events in one cycle all land, since each owns its own bit.

  // Limitations a user must know.
  // Byte strobes apply to clears as well, so a partial write clears only its lanes.
  // The status word cannot be set by software; there is no test-set path.
  // A DMA cause arriving between the two clearing writes keeps the summary bit set.
  // That is wanted, since software sees the new cause on its next read.
  // The mask only gates INT; masked sources still record in the status word.
  // A read in the cycle of a committing write returns the value before the write.

  // All state of the block in one word.
  typedef struct packed {
    // Write address channel.
    logic          aw_rdy;
    logic          aw_got;
    logic [AW-1:0] aw_addr;
    // Write data channel and write response.
    logic          w_rdy;
    logic          w_got;
    logic [DW-1:0] w_data;
    logic [SW-1:0] w_strb;
    logic          b_vld;
    logic [1:0]    b_resp;
    // Read address and read data channels.
    logic          ar_rdy;
    logic          r_vld;
    logic [DW-1:0] r_data;
    logic [1:0]    r_resp;
    // Software-visible registers and the registered interrupt line.
    logic [DW-1:0] status;
    logic [DW-1:0] mask;
    logic [RW-1:0] reason;
    logic          irq;
  } pis_state_t;

  pis_state_t st_ff;
  pis_state_t nxt_st;

  // Decodes a bus address into a register selector; used for reads and writes.
  // Only whole aligned words match, so any other address falls to the error answer.
  function automatic pis_pkg::pis_sel_t pis_decode(input logic [AW-1:0] addr);
    pis_pkg::pis_sel_t sel;
    case (addr)
      pis_pkg::OFS_STATUS: sel = pis_pkg::PIS_SEL_STATUS;
      pis_pkg::OFS_MASK:   sel = pis_pkg::PIS_SEL_MASK;
      pis_pkg::OFS_REASON: sel = pis_pkg::PIS_SEL_REASON;
      default:             sel = pis_pkg::PIS_SEL_NONE;
    endcase
    return sel;
  endfunction : pis_decode

  // Expands byte strobes into a bit mask so partial writes touch only their lanes.
  // It serves the status clear, the mask update and the cause clear alike.
  function automatic logic [DW-1:0] pis_lanes(input logic [SW-1:0] strb);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < SW; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : pis_lanes

  // Marks the status bits that exist; the rest are reserved and read as zero.
  // It is evaluated once at elaboration and costs no logic.
  function automatic logic [DW-1:0] pis_impl();
    logic [DW-1:0] m;
    m = '0;
    m[pis_pkg::BIT_BUS_RESET] = 1'b1;
    m[pis_pkg::BIT_RESUME]    = 1'b1;
    m[pis_pkg::BIT_SUSPEND]   = 1'b1;
    m[pis_pkg::BIT_PSOF]      = 1'b1;
    m[pis_pkg::BIT_SOF]       = 1'b1;
    m[pis_pkg::BIT_DMA]       = 1'b1;
    for (int n = 0; n < NUM_EP; n++) begin
      m[pis_pkg::EP_BASE + 2*n]     = 1'b1;
      m[pis_pkg::EP_BASE + 2*n + 1] = 1'b1;
    end
    return m;
  endfunction : pis_impl

  localparam logic [DW-1:0] IMPL_MASK = pis_impl();

  // Transmit and receive events of each endpoint, interleaved in pairs.
  logic [2*NUM_EP-1:0] ep_pair;

  // One copy of the pairing per endpoint; transmit takes the even position.
  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    assign ep_pair[2*n]     = EP_TX_EVT[n];
    assign ep_pair[2*n + 1] = EP_RX_EVT[n];
  end

  // Working values of the register update, filled at the top of the process.
  // The flag wr_go marks the one cycle in which a held write commits.
  logic [DW-1:0]      ev_vec;
  logic [DW-1:0]      wr_bits;
  logic [DW-1:0]      st_clr;
  logic [RW-1:0]      rs_clr;
  pis_pkg::pis_sel_t  wr_sel;
  pis_pkg::pis_sel_t  rd_sel;
  logic               wr_go;

  // Next-state logic: bus handshakes, sticky status, mask and DMA cause register.
  always_comb begin
    nxt_st  = st_ff;
    ev_vec  = '0;
    st_clr  = '0;
    rs_clr  = '0;
    wr_bits = st_ff.w_data & pis_lanes(st_ff.w_strb);
    wr_sel  = pis_decode(st_ff.aw_addr);
    rd_sel  = pis_decode(ARADDR);
    wr_go   = st_ff.aw_got && st_ff.w_got && !st_ff.b_vld;

    // Bus-state events each own a bit of their own.
    ev_vec[pis_pkg::BIT_BUS_RESET] = BUS_RESET_EVT;
    ev_vec[pis_pkg::BIT_RESUME]    = RESUME_EVT;
    ev_vec[pis_pkg::BIT_SUSPEND]   = SUSPEND_EVT;
    ev_vec[pis_pkg::BIT_PSOF]      = PSOF_EVT;
    ev_vec[pis_pkg::BIT_SOF]       = SOF_EVT;
    // Every DMA cause funnels into the single summary bit.
    ev_vec[pis_pkg::BIT_DMA]       = |DMA_REASON_EVT;

    // Each endpoint reports transmit and receive on neighbouring bits.
    ev_vec[pis_pkg::EP_BASE +: 2*NUM_EP] = ep_pair;

    // Write address and write data are taken independently, in either order.
    // A taken half is held here until the write commits.
    if (AWVALID && st_ff.aw_rdy) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = AWADDR;
      nxt_st.aw_rdy  = 1'b0;
    end
    if (WVALID && st_ff.w_rdy) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = WDATA;
      nxt_st.w_strb = WSTRB;
      nxt_st.w_rdy  = 1'b0;
    end

    // Once both halves are held, the write is carried out and answered.
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.b_vld  = 1'b1;
      nxt_st.b_resp = pis_pkg::RESP_OKAY;
      case (wr_sel)
        pis_pkg::PIS_SEL_STATUS: begin
          // Ones clear, zeros leave the bit alone.
          st_clr = wr_bits & IMPL_MASK;
        end
        pis_pkg::PIS_SEL_MASK: begin
          // Only enabled lanes change; reserved bits stay zero.
          nxt_st.mask = (st_ff.mask & ~pis_lanes(st_ff.w_strb))
                      | (wr_bits & IMPL_MASK);
        end
        pis_pkg::PIS_SEL_REASON: begin
          // Ones clear causes; the summary bit needs its own write afterwards.
          rs_clr = wr_bits[RW-1:0];
        end
        default: begin
          // Nothing changes; the master is told by the response code.
          nxt_st.b_resp = pis_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Ready again only after the master has taken the response.
    // This is what keeps a second write out while one is still answered.
    if (st_ff.b_vld && BREADY) begin
      nxt_st.b_vld  = 1'b0;
      nxt_st.aw_rdy = 1'b1;
      nxt_st.w_rdy  = 1'b1;
    end

    // The cause register is sticky; a new cause beats a clear in the same cycle.
    nxt_st.reason = (st_ff.reason & ~rs_clr) | DMA_REASON_EVT;

    // The summary DMA bit only drops once no cause remains pending.
    // Clearing it while a cause remains would hide that cause from software.
    // A cause that arrives in the clearing cycle itself also keeps the bit.
    if (nxt_st.reason != '0) begin
      st_clr[pis_pkg::BIT_DMA] = 1'b0;
    end

    // Set wins over clear, so an event landing on a clear is never lost.
    nxt_st.status = ((st_ff.status & ~st_clr) | ev_vec) & IMPL_MASK;

    // The line follows the unmasked content; mask resets open so any set bit shows.
    // It is taken from the next state so INT moves in the same cycle as the status.
    // A cleared last source therefore drops INT as the clearing write commits.
    // Unmasking a pending source raises INT as the mask write commits.
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);

    // Reads answer one cycle after the address is taken, with no side effects.
    // The read data stands unchanged until the master accepts it.
    if (ARVALID && st_ff.ar_rdy) begin
      nxt_st.ar_rdy = 1'b0;
      nxt_st.r_vld  = 1'b1;
      nxt_st.r_resp = pis_pkg::RESP_OKAY;
      case (rd_sel)
        pis_pkg::PIS_SEL_STATUS: begin
          nxt_st.r_data = st_ff.status;
        end
        pis_pkg::PIS_SEL_MASK: begin
          nxt_st.r_data = st_ff.mask;
        end
        pis_pkg::PIS_SEL_REASON: begin
          // The cause word is narrower than the bus and is padded with zeros.
          nxt_st.r_data = {{(DW-RW){1'b0}}, st_ff.reason};
        end
        default: begin
          // Zero data leaks nothing of the mapped registers.
          nxt_st.r_data = '0;
          nxt_st.r_resp = pis_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.r_vld && RREADY) begin
      nxt_st.r_vld  = 1'b0;
      nxt_st.ar_rdy = 1'b1;
    end
  end

  // State register; every field takes a constant under reset.
  // Reset leaves all channels ready, no answer pending and no source recorded.
  // The mask resets open so that any recorded source shows on INT at once.
  // A reset in mid-transfer drops that transfer; the master must start again.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      // Write channels ready, nothing held.
      st_ff.aw_rdy  <= 1'b1;
      st_ff.aw_got  <= 1'b0;
      st_ff.aw_addr <= '0;
      st_ff.w_rdy   <= 1'b1;
      st_ff.w_got   <= 1'b0;
      st_ff.w_data  <= '0;
      st_ff.w_strb  <= '0;

      // No write response pending.
      st_ff.b_vld   <= 1'b0;
      st_ff.b_resp  <= pis_pkg::RESP_OKAY;

      // Read channel ready, no data pending.
      st_ff.ar_rdy  <= 1'b1;
      st_ff.r_vld   <= 1'b0;
      st_ff.r_data  <= '0;
      st_ff.r_resp  <= pis_pkg::RESP_OKAY;

      // Registers cleared and the mask open.
      st_ff.status  <= pis_pkg::STATUS_RST;
      st_ff.mask    <= pis_pkg::MASK_RST & IMPL_MASK;
      st_ff.reason  <= '0;
      st_ff.irq     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign AWREADY = st_ff.aw_rdy;
  assign WREADY  = st_ff.w_rdy;
  assign BVALID  = st_ff.b_vld;
  assign BRESP   = st_ff.b_resp;
  assign ARREADY = st_ff.ar_rdy;
  assign RVALID  = st_ff.r_vld;
  assign RDATA   = st_ff.r_data;
  assign RRESP   = st_ff.r_resp;
  assign INT     = st_ff.irq;

endmodule : pis_irq_status

// File: verif/pis_irq_status_chk.sv
`timescale 1ns/1ps

// Watches interrupt and bus answer timing at the ports of the status block.
module pis_irq_chk #(
  parameter int unsigned NUM_EP = 8
) (
  input wire logic              CLK,
  input wire logic              RESET,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic [7:0]        AWADDR,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [31:0]       WDATA,
  input wire logic              BVALID,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic              RVALID,
  input wire logic [NUM_EP-1:0] EP_TX_EVT,
  input wire logic [NUM_EP-1:0] EP_RX_EVT,
  input wire logic              SOF_EVT,
  input wire logic [15:0]       DMA_REASON_EVT,
  input wire logic              INT
);
  logic        wr_go;
  logic [31:0] msk_ff;

  // Mask mirror taken at the handshake, since the bench sends no event while a write is open.
  assign wr_go = AWVALID && AWREADY && WVALID && WREADY;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) msk_ff <= 32'hffff_ffff;
    else if (wr_go && AWADDR == pis_pkg::OFS_MASK) msk_ff <= WDATA;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sof_sets_a: assert property (SOF_EVT && msk_ff[4] |=> INT)
    else $error("SOF event left INT low");
  tx_sets_a: assert property (EP_TX_EVT[0] && msk_ff[8] |=> INT)
    else $error("transmit event left INT low");
  rx_sets_a: assert property (EP_RX_EVT[1] && msk_ff[11] |=> INT)
    else $error("receive event left INT low");
  dma_sets_a: assert property (|DMA_REASON_EVT && msk_ff[5] |=> INT)
    else $error("DMA event left INT low");
  int_fall_a: assert property ($fell(INT) |-> $rose(BVALID))
    else $error("INT fell without a write");
  zero_keeps_a: assert property (wr_go && AWADDR == 8'h00 && WDATA == 32'h0 && INT
    |-> ##2 INT)
    else $error("zero write dropped INT");
  wr_answer_a: assert property (wr_go |-> ##2 BVALID)
    else $error("write response late");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
endmodule : pis_irq_chk

bind pis_irq_status pis_irq_chk #(.NUM_EP(NUM_EP)) u_chk (
  .CLK, .RESET, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .BVALID,
  .ARVALID, .ARREADY, .RVALID, .EP_TX_EVT, .EP_RX_EVT, .SOF_EVT, .DMA_REASON_EVT, .INT
);

// File: verif/pis_cpu_model.sv
`timescale 1ns/1ps

// Processor side of the register bus; released lines carry inverted values.
module pis_cpu_model (
  input wire logic        CLK,
  output logic            AWVALID,
  input wire logic        AWREADY,
  output logic [7:0]      AWADDR,
  output logic            WVALID,
  input wire logic        WREADY,
  output logic [31:0]     WDATA,
  output logic [3:0]      WSTRB,
  input wire logic        BVALID,
  output logic            BREADY,
  input wire logic [1:0]  BRESP,
  output logic            ARVALID,
  input wire logic        ARREADY,
  output logic [7:0]      ARADDR,
  input wire logic        RVALID,
  output logic            RREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP
);
  // Idle bus at time zero.
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hf;
  end

  // Address and data go out together and each is dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    @(posedge CLK);
    {AWVALID, WVALID, BREADY} <= 3'h7;
    AWADDR <= a;
    WDATA  <= d;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge CLK);
      if (pa && AWREADY) begin
        pa = 1'b0;
        AWVALID <= 1'b0;
        AWADDR  <= ~a;
      end
      if (pw && WREADY) begin
        pw = 1'b0;
        WVALID <= 1'b0;
        WDATA  <= ~d;
      end
    end
    do @(posedge CLK); while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask : wr

  // A status read is how INT is serviced; the source is found in the word.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    {ARVALID, RREADY} <= 2'h3;
    ARADDR <= a;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    ARADDR  <= ~a;
    while (!RVALID) @(posedge CLK);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask : rd
endmodule : pis_cpu_model

// File: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic        CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, INT;
  logic        BUS_RESET_EVT, RESUME_EVT, SUSPEND_EVT, PSOF_EVT, SOF_EVT;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, EP_TX_EVT, EP_RX_EVT, r;
  logic [15:0] DMA_REASON_EVT;
  logic [8:0]  evt;
  int          err_total = 0;
  int          total_checks = 0;
  // Rows: one event input beside the status word it should give.
  logic [8:0]  ev_tab [9] = '{9'h1, 9'h2, 9'h4, 9'h8, 9'h10, 9'h20, 9'h40, 9'h80, 9'h100};
  logic [31:0] ex_tab [9] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h100, 32'h400,
                              32'h200, 32'h800};

  assign {EP_RX_EVT, EP_TX_EVT, SOF_EVT, PSOF_EVT, SUSPEND_EVT, RESUME_EVT, BUS_RESET_EVT} = evt;
  pis_irq_status #(.NUM_EP(2)) uut (.CLK, .RESET, .AWVALID, .AWREADY, .AWADDR, .WVALID,
    .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID,
    .RREADY, .RDATA, .RRESP, .EP_TX_EVT, .EP_RX_EVT, .BUS_RESET_EVT, .RESUME_EVT,
    .SUSPEND_EVT, .PSOF_EVT, .SOF_EVT, .DMA_REASON_EVT, .INT);
  pis_cpu_model u_cpu (.CLK, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP);

  always #5 CLK = ~CLK;

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check

  // Reads a word and compares it; the response must be OKAY.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    u_cpu.rd(a, d, r);
    check("rdata", d, e);
    check("rresp", 32'(r), 32'h0);
  endtask : rchk

  // One event pulse; INT is looked at once the setting edge has landed.
  task automatic pulse(input logic [8:0] v, input logic [15:0] dv);
    @(posedge CLK);
    evt <= v;
    DMA_REASON_EVT <= dv;
    @(posedge CLK);
    evt <= 9'h0;
    DMA_REASON_EVT <= 16'h0;
    @(negedge CLK);
  endtask : pulse

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, far beyond the few hundred cycles the run needs.
  initial begin
    repeat (5000) @(posedge CLK);
    err_total++;
    tally_and_finish;
  end

  // Main sequence: reset values, then the table loop, masking, the DMA summary and error paths.
  initial begin
    {CLK, RESET, evt, DMA_REASON_EVT} = {2'h1, 25'h0};
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    rchk(pis_pkg::OFS_STATUS, 32'h0);
    rchk(pis_pkg::OFS_MASK, 32'hf3f);
    for (int i = 0; i < 9; i++) begin
      pulse(ev_tab[i], 16'h0);
      check("int", 32'(INT), 32'h1);
      rchk(pis_pkg::OFS_STATUS, ex_tab[i]);
      u_cpu.wr(pis_pkg::OFS_STATUS, 32'h0, r);
      rchk(pis_pkg::OFS_STATUS, ex_tab[i]);
      u_cpu.wr(pis_pkg::OFS_STATUS, ex_tab[i], r);
      check("bresp", 32'(r), 32'h0);
      rchk(pis_pkg::OFS_STATUS, 32'h0);
      check("int", 32'(INT), 32'h0);
    end
    pulse(9'h12, 16'h0);
    u_cpu.wr(pis_pkg::OFS_STATUS, 32'h10, r);
    rchk(pis_pkg::OFS_STATUS, 32'h2);
    check("int", 32'(INT), 32'h1);
    u_cpu.wr(pis_pkg::OFS_STATUS, 32'h2, r);
    u_cpu.wr(pis_pkg::OFS_MASK, 32'hf2f, r);
    pulse(9'h10, 16'h0);
    check("int", 32'(INT), 32'h0);
    rchk(pis_pkg::OFS_STATUS, 32'h10);
    u_cpu.wr(pis_pkg::OFS_MASK, 32'hf3f, r);
    check("int", 32'(INT), 32'h1);
    u_cpu.wr(pis_pkg::OFS_STATUS, 32'h10, r);
    pulse(9'h0, 16'h8);
    rchk(pis_pkg::OFS_REASON, 32'h8);
    rchk(pis_pkg::OFS_STATUS, 32'h20);
    u_cpu.wr(pis_pkg::OFS_STATUS, 32'h20, r);
    rchk(pis_pkg::OFS_STATUS, 32'h20);
    u_cpu.wr(pis_pkg::OFS_REASON, 32'h8, r);
    u_cpu.wr(pis_pkg::OFS_STATUS, 32'h20, r);
    rchk(pis_pkg::OFS_STATUS, 32'h0);
    u_cpu.wr(8'h0c, 32'hffff_ffff, r);
    check("bresp", 32'(r), 32'(pis_pkg::RESP_SLVERR));
    u_cpu.rd(8'h0c, d, r);
    check("rdata", d, 32'h0);
    check("rresp", 32'(r), 32'(pis_pkg::RESP_SLVERR));
    pulse(9'h10, 16'h0);
    check("int", 32'(INT), 32'h1);
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    check("int", 32'(INT), 32'h0);
    RESET <= 1'b0;
    rchk(pis_pkg::OFS_STATUS, 32'h0);
    check("int", 32'(INT), 32'h0);
    rchk(pis_pkg::OFS_MASK, 32'hf3f);
    tally_and_finish;
  end
endmodule : tb_top
